// file: design/pin_select_map.svh
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

// Register offsets
`define REG_RSVD_A        8'h32
`define REG_MPP_CTRL      8'h33
`define REG_RSVD_B        8'h34
`define REG_DOUT_CTRL     8'h35
`define REG_DIN_CTRL      8'h36

// Reset values
`define RST_RSVD_A        8'h00
`define RST_MPP_CTRL      8'h00
`define RST_RSVD_B        8'h00
`define RST_DOUT_CTRL     8'h12
`define RST_DIN_CTRL      8'h02

// Multi-purpose pin function codes
`define MPP_FN_OFF        4'h0
`define MPP_FN_IN         4'h1
`define MPP_FN_GEN_IN     4'h2
`define MPP_FN_GPO        4'h3
`define MPP_FN_CLK_OUT    4'h4
`define MPP_FN_IRQ_A      4'h5
`define MPP_FN_IRQ_B      4'h6
`define MPP_FN_ADC_WCLK   4'h7
`define MPP_FN_SEC_BCLK   4'h8
`define MPP_FN_SEC_WCLK   4'h9
`define MPP_FN_MIC_CLK    4'hA
`define MPP_FN_SEC_DOUT   4'hB
`define MPP_FN_LAST       4'hB

// Data-output pin selector codes
`define DOUT_SEL_OFF      3'h0
`define DOUT_SEL_PRIMARY  3'h1
`define DOUT_SEL_GPO      3'h2
`define DOUT_SEL_CLK_OUT  3'h3
`define DOUT_SEL_IRQ_A    3'h4
`define DOUT_SEL_IRQ_B    3'h5
`define DOUT_SEL_SEC_BCLK 3'h6
`define DOUT_SEL_SEC_WCLK 3'h7

// Data-input pin selector codes
`define DIN_SEL_OFF       2'h0
`define DIN_SEL_ON        2'h1
`define DIN_SEL_GEN_IN    2'h2

// Interrupt pulse timing
`define SYS_CLK_HZ        20000000
`define INT_PULSE_US      2000
`define INT_PERIOD_US     4000
`define INT_PULSE_CYC     (`INT_PULSE_US * (`SYS_CLK_HZ / 1000000))
`define INT_PERIOD_CYC    (`INT_PERIOD_US * (`SYS_CLK_HZ / 1000000))

`endif

// file: design/pin_select_pkg.sv
package pin_select_pkg;

	// Multi-purpose pin control register layout
	typedef struct packed {
		logic [1:0] rsvd;
		logic [3:0] func;
		logic       level;
		logic       gpo;
	} mpp_reg_type;

	// Data-output pin control register layout
	typedef struct packed {
		logic [2:0] rsvd;
		logic       keeper_off;
		logic [2:0] sel;
		logic       gpo;
	} dout_reg_type;

	// Data-input pin control register layout
	typedef struct packed {
		logic [4:0] rsvd;
		logic [1:0] sel;
		logic       level;
	} din_reg_type;

	// Interrupt pulse shaper states, Gray along idle-high-low
	typedef enum logic [1:0] {
		SHP_IDLE = 2'h0,
		SHP_HIGH = 2'h1,
		SHP_LOW  = 2'h3
	} shaper_state_type;

	typedef struct packed {
		shaper_state_type st;
		logic             rep;
		logic [16:0]      cnt;
	} shaper_type;

	// Output drive of one pin
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_type;

	typedef struct packed {
		logic [7:0]      rsvd_a;
		logic [7:0]      rsvd_b;
		mpp_reg_type     mpp;
		dout_reg_type    dout;
		din_reg_type     din;
		logic [7:0]      rdata;
		shaper_type [1:0] shp;
		logic [1:0]      int_lvl;
		pin_drive_type   mpp_pin;
		pin_drive_type   dout_pin;
		logic            mpp_ibuf;
		logic            din_ibuf;
		logic            keeper_en;
		logic            mpp_route;
		logic            din_route;
	} state_type;

endpackage

// file: design/pin_function_select.sv
`timescale 1ns/1ns
`include "pin_select_map.svh"
// What this block does
// - Code 0000 powers down both pin buffers
// - Code 0001 feeds pin level to internal sinks
// - Code 0010 makes pin a readable general input
// - Code 0011 drives register general output bit
// - Codes 0100-0110 route clock, interrupt one, two
// - Codes 0111-1001 drive ADC, secondary bit, word clocks
// - Code 1011 drives secondary data; 1100-1111 reserved
// - Bit 1 reads multi-purpose input buffer level
// - Bit 0 sets multi-purpose output level, reset 0
// - Data-output bit 4 disables keeper, reset off
// - Selector 000 off, 001 primary, 010 general
// - Selector 011-101 route clock and interrupts
// - Selector 110, 111 drive secondary clocks
// - Data-output bit 0 is general output level
// - Data-input selector: off, on, general input
// - Data-input bit 0 reads input buffer level
// - Interrupts: 2 ms pulse or 4 ms repeats
module pin_function_select #(
	parameter int INT_PULSE_CYC  = `INT_PULSE_CYC,
	parameter int INT_PERIOD_CYC = `INT_PERIOD_CYC
) (
	// Clock and reset
	input  logic                          sys_clk,
	input  logic                          rst_n,
	// Register port
	input  logic [7:0]                    reg_addr,
	input  logic [7:0]                    reg_wdata,
	input  logic                          reg_wr,
	input  logic                          reg_rd,
	output logic [7:0]                    reg_rdata,
	// Internal sources that may be routed out
	input  logic                          clock_output_signal,
	input  logic                          adc_word_clock,
	input  logic                          secondary_bit_clock,
	input  logic                          secondary_word_clock,
	input  logic                          secondary_data_out,
	input  logic                          mic_modulator_clock,
	input  logic                          primary_data_out,
	// Interrupt requests and shaped outputs
	input  logic [1:0]                    int_event,
	input  logic [1:0]                    int_repeat,
	input  logic                          int_flags_read,
	output logic                          first_interrupt_output,
	output logic                          second_interrupt_output,
	// Multi-purpose pin
	input  logic                          multi_purpose_pin_in,
	output pin_select_pkg::pin_drive_type multi_purpose_pin_drive,
	output logic                          multi_purpose_pin_ibuf_en,
	output logic                          multi_purpose_pin_route,
	// Data-output pin
	output pin_select_pkg::pin_drive_type data_out_pin_drive,
	output logic                          data_out_pin_keeper_en,
	// Data-input pin
	input  logic                          data_in_pin_in,
	output logic                          data_in_pin_ibuf_en,
	output logic                          data_in_pin_route
);
	import pin_select_pkg::*;

	localparam logic [16:0] PULSE_LAST  = 17'(INT_PULSE_CYC - 1);
	localparam logic [16:0] PERIOD_LAST = 17'(INT_PERIOD_CYC - 1);

	state_type  state_ff;
	state_type  nxt_state;
	shaper_type nxt_shp [2];

	// Interrupt pulse shapers, one per interrupt output
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_shaper
			always_comb begin
				nxt_shp[g] = state_ff.shp[g];
				case (state_ff.shp[g].st)
					SHP_IDLE: begin
						nxt_shp[g].cnt = 17'h0;
					end
					SHP_HIGH: begin
						nxt_shp[g].cnt = state_ff.shp[g].cnt + 17'h1;
						if (state_ff.shp[g].cnt == PULSE_LAST) begin
							nxt_shp[g].st = state_ff.shp[g].rep ? SHP_LOW : SHP_IDLE;
						end
					end
					SHP_LOW: begin
						nxt_shp[g].cnt = state_ff.shp[g].cnt + 17'h1;
						if (!state_ff.shp[g].rep) begin
							nxt_shp[g].st = SHP_IDLE;
						end else if (state_ff.shp[g].cnt == PERIOD_LAST) begin
							nxt_shp[g].st  = SHP_HIGH;
							nxt_shp[g].cnt = 17'h0;
						end
					end
					default: begin
						nxt_shp[g].st  = SHP_IDLE;
						nxt_shp[g].cnt = 17'h0;
					end
				endcase
				// Reading the flags stops repeats after the pulse under way
				if (int_flags_read) begin
					nxt_shp[g].rep = 1'b0;
				end
				// A new event wins over a flag read in the same cycle
				if (int_event[g]) begin
					nxt_shp[g].st  = SHP_HIGH;
					nxt_shp[g].cnt = 17'h0;
					nxt_shp[g].rep = int_repeat[g];
				end
			end
		end
	endgenerate

	// Register writes, reads, pin selection and routing
	always_comb begin
		nxt_state = state_ff;
		nxt_state.shp[0] = nxt_shp[0];
		nxt_state.shp[1] = nxt_shp[1];
		nxt_state.int_lvl[0] = (nxt_shp[0].st == SHP_HIGH);
		nxt_state.int_lvl[1] = (nxt_shp[1].st == SHP_HIGH);

		// Buffer levels only follow the pin while the buffer is powered
		nxt_state.mpp.level = state_ff.mpp_ibuf & multi_purpose_pin_in;
		nxt_state.din.level = state_ff.din_ibuf & data_in_pin_in;

		// Reserved fields simply hold what software writes
		if (reg_wr) begin
			case (reg_addr)
				`REG_RSVD_A: begin
					nxt_state.rsvd_a = reg_wdata;
				end
				`REG_MPP_CTRL: begin
					nxt_state.mpp.rsvd = reg_wdata[7:6];
					nxt_state.mpp.func = reg_wdata[5:2];
					nxt_state.mpp.gpo  = reg_wdata[0];
				end
				`REG_RSVD_B: begin
					nxt_state.rsvd_b = reg_wdata;
				end
				`REG_DOUT_CTRL: begin
					nxt_state.dout.rsvd       = reg_wdata[7:5];
					nxt_state.dout.keeper_off = reg_wdata[4];
					nxt_state.dout.sel        = reg_wdata[3:1];
					nxt_state.dout.gpo        = reg_wdata[0];
				end
				`REG_DIN_CTRL: begin
					nxt_state.din.rsvd = reg_wdata[7:3];
					nxt_state.din.sel  = reg_wdata[2:1];
				end
				default: begin
				end
			endcase
		end

		// Read data stands for exactly one cycle; unmapped reads give zero
		nxt_state.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`REG_RSVD_A:    nxt_state.rdata = state_ff.rsvd_a;
				`REG_MPP_CTRL:  nxt_state.rdata = state_ff.mpp;
				`REG_RSVD_B:    nxt_state.rdata = state_ff.rsvd_b;
				`REG_DOUT_CTRL: nxt_state.rdata = state_ff.dout;
				`REG_DIN_CTRL:  nxt_state.rdata = state_ff.din;
				default:        nxt_state.rdata = 8'h00;
			endcase
		end

		// Multi-purpose pin; decoded from the new control value
		nxt_state.mpp_pin.out = 1'b0;
		nxt_state.mpp_pin.oe  = 1'b1;
		nxt_state.mpp_ibuf    = 1'b1;
		nxt_state.mpp_route   = 1'b0;
		case (nxt_state.mpp.func)
			`MPP_FN_OFF: begin
				nxt_state.mpp_pin.oe = 1'b0;
				nxt_state.mpp_ibuf   = 1'b0;
			end
			`MPP_FN_IN: begin
				nxt_state.mpp_pin.oe = 1'b0;
				nxt_state.mpp_route  = multi_purpose_pin_in;
			end
			`MPP_FN_GEN_IN: begin
				nxt_state.mpp_pin.oe = 1'b0;
			end
			`MPP_FN_GPO:      nxt_state.mpp_pin.out = nxt_state.mpp.gpo;
			`MPP_FN_CLK_OUT:  nxt_state.mpp_pin.out = clock_output_signal;
			`MPP_FN_IRQ_A:    nxt_state.mpp_pin.out = nxt_state.int_lvl[0];
			`MPP_FN_IRQ_B:    nxt_state.mpp_pin.out = nxt_state.int_lvl[1];
			`MPP_FN_ADC_WCLK: nxt_state.mpp_pin.out = adc_word_clock;
			`MPP_FN_SEC_BCLK: nxt_state.mpp_pin.out = secondary_bit_clock;
			`MPP_FN_SEC_WCLK: nxt_state.mpp_pin.out = secondary_word_clock;
			`MPP_FN_MIC_CLK:  nxt_state.mpp_pin.out = mic_modulator_clock;
			`MPP_FN_SEC_DOUT: nxt_state.mpp_pin.out = secondary_data_out;
			default: begin
				// Reserved codes: nothing driven, nothing sensed
				nxt_state.mpp_pin.oe = 1'b0;
				nxt_state.mpp_ibuf   = 1'b0;
			end
		endcase

		// Data-output pin
		nxt_state.keeper_en    = ~nxt_state.dout.keeper_off;
		nxt_state.dout_pin.oe  = 1'b1;
		nxt_state.dout_pin.out = 1'b0;
		case (nxt_state.dout.sel)
			`DOUT_SEL_OFF:      nxt_state.dout_pin.oe  = 1'b0;
			`DOUT_SEL_PRIMARY:  nxt_state.dout_pin.out = primary_data_out;
			`DOUT_SEL_GPO:      nxt_state.dout_pin.out = nxt_state.dout.gpo;
			`DOUT_SEL_CLK_OUT:  nxt_state.dout_pin.out = clock_output_signal;
			`DOUT_SEL_IRQ_A:    nxt_state.dout_pin.out = nxt_state.int_lvl[0];
			`DOUT_SEL_IRQ_B:    nxt_state.dout_pin.out = nxt_state.int_lvl[1];
			`DOUT_SEL_SEC_BCLK: nxt_state.dout_pin.out = secondary_bit_clock;
			`DOUT_SEL_SEC_WCLK: nxt_state.dout_pin.out = secondary_word_clock;
			default:            nxt_state.dout_pin.oe  = 1'b0;
		endcase

		// Data-input pin; general input mode is readback only
		nxt_state.din_ibuf  = 1'b0;
		nxt_state.din_route = 1'b0;
		case (nxt_state.din.sel)
			`DIN_SEL_OFF: nxt_state.din_ibuf = 1'b0;
			`DIN_SEL_ON: begin
				nxt_state.din_ibuf  = 1'b1;
				nxt_state.din_route = data_in_pin_in;
			end
			`DIN_SEL_GEN_IN: nxt_state.din_ibuf = 1'b1;
			default:      nxt_state.din_ibuf = 1'b0;
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_ff           <= '0;
			state_ff.rsvd_a    <= `RST_RSVD_A;
			state_ff.rsvd_b    <= `RST_RSVD_B;
			state_ff.mpp       <= `RST_MPP_CTRL;
			state_ff.dout      <= `RST_DOUT_CTRL;
			state_ff.din       <= `RST_DIN_CTRL;
			state_ff.keeper_en <= 1'b0;
			state_ff.dout_pin  <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs come straight from the state register
	assign reg_rdata                 = state_ff.rdata;
	assign first_interrupt_output    = state_ff.int_lvl[0];
	assign second_interrupt_output   = state_ff.int_lvl[1];
	assign multi_purpose_pin_drive   = state_ff.mpp_pin;
	assign multi_purpose_pin_ibuf_en = state_ff.mpp_ibuf;
	assign multi_purpose_pin_route   = state_ff.mpp_route;
	assign data_out_pin_drive        = state_ff.dout_pin;
	assign data_out_pin_keeper_en    = state_ff.keeper_en;
	assign data_in_pin_ibuf_en       = state_ff.din_ibuf;
	assign data_in_pin_route         = state_ff.din_route;

	// Checks on pin selection
	chk_mpp_off_buffers: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.mpp.func == `MPP_FN_OFF |-> !multi_purpose_pin_drive.oe && !multi_purpose_pin_ibuf_en)
		else $error("multi-purpose pin buffers not off");
	chk_mpp_gpo_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.mpp.func == `MPP_FN_GPO |->
			multi_purpose_pin_drive.oe && multi_purpose_pin_drive.out == state_ff.mpp.gpo)
		else $error("multi-purpose pin not at general output level");
	chk_mpp_int_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.mpp.func == `MPP_FN_IRQ_B |->
			multi_purpose_pin_drive.out == second_interrupt_output)
		else $error("second interrupt not on multi-purpose pin");
	chk_mpp_mic_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.mpp.func == `MPP_FN_MIC_CLK |->
			multi_purpose_pin_drive.oe && multi_purpose_pin_drive.out == $past(mic_modulator_clock))
		else $error("mic clock not on multi-purpose pin");
	chk_mpp_reserved_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.mpp.func > `MPP_FN_LAST |->
			!multi_purpose_pin_drive.oe && !multi_purpose_pin_ibuf_en && !multi_purpose_pin_route)
		else $error("reserved code drives or routes the pin");
	chk_dout_keeper_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		data_out_pin_keeper_en == !state_ff.dout.keeper_off)
		else $error("keeper enable disagrees with control bit");
	// Pin drive still shows its cleared image on the first edge after reset
	chk_dout_primary_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.dout.sel == `DOUT_SEL_PRIMARY && $past(rst_n) |->
			data_out_pin_drive.oe && data_out_pin_drive.out == $past(primary_data_out))
		else $error("primary data not on data-output pin");
	chk_din_powered_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_ff.din.sel == `DIN_SEL_OFF |->
			(!data_in_pin_route && !data_in_pin_ibuf_en) ##1 !state_ff.din.level)
		else $error("disabled data-input pin still senses");
	chk_din_read_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == `REG_DIN_CTRL |=> reg_rdata[0] == $past(state_ff.din.level))
		else $error("data-input level readback wrong");

	// Checks on interrupt pulse shaping
	chk_int_pulse_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
		first_interrupt_output |-> state_ff.shp[0].cnt <= PULSE_LAST)
		else $error("first interrupt pulse too long");
	chk_int_event_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_event[1] |=> second_interrupt_output ##1 second_interrupt_output)
		else $error("second interrupt pulse did not start");

endmodule

// file: tb/pin_far_side.sv
`timescale 1ns/1ns
// Far side of one codec pin: owns the line only while the codec leaves it undriven
module pin_far_side (
	// Clock
	input  wire logic                          sys_clk,
	// Codec drive and outside level
	input  wire pin_select_pkg::pin_drive_type drive,
	input  wire logic                          ext_en,
	input  wire logic                          ext_level,
	// Resolved pin level
	output logic                               level
);
	import pin_select_pkg::*;

	logic stale = 1'h0;

	// No pull on this line, so a floating pin must not look like a steady value
	always @(posedge sys_clk) begin
		stale <= ~stale;
	end

	// Codec drive wins; the outside party backs off while the codec drives
	assign level = drive.oe ? drive.out : (ext_en ? ext_level : stale);
endmodule

// file: tb/audio_codec_pin_function_select_tb_top.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module audio_codec_pin_function_select_tb_top;
	import pin_select_pkg::*;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] code;
		logic [2:0] flg;
		logic [3:0] idx;
	} row_type;

	logic          sys_clk, rst_n, reg_wr, reg_rd, int_flags_read;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata;
	logic          clock_output_signal, adc_word_clock, secondary_bit_clock;
	logic          secondary_word_clock, secondary_data_out, mic_modulator_clock;
	logic          primary_data_out, first_interrupt_output, second_interrupt_output;
	logic [1:0]    int_event, int_repeat;
	logic          multi_purpose_pin_in, multi_purpose_pin_ibuf_en, multi_purpose_pin_route;
	logic          data_out_pin_keeper_en, data_in_pin_in, data_in_pin_ibuf_en;
	logic          data_in_pin_route, mpp_ext, din_ext;
	pin_drive_type multi_purpose_pin_drive, data_out_pin_drive;
	int            miscompares, comparisons, cycles;
	row_type       rows [28];

	// Short interrupt timing keeps the run brief
	pin_function_select #(.INT_PULSE_CYC(4), .INT_PERIOD_CYC(8)) pin_function_select_i (
		.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.clock_output_signal, .adc_word_clock, .secondary_bit_clock, .secondary_word_clock,
		.secondary_data_out, .mic_modulator_clock, .primary_data_out, .int_event,
		.int_repeat, .int_flags_read, .first_interrupt_output, .second_interrupt_output,
		.multi_purpose_pin_in, .multi_purpose_pin_drive, .multi_purpose_pin_ibuf_en,
		.multi_purpose_pin_route, .data_out_pin_drive, .data_out_pin_keeper_en,
		.data_in_pin_in, .data_in_pin_ibuf_en, .data_in_pin_route);

	// Far side of the multi-purpose pin and of the data-input pin
	pin_far_side pin_far_side_i (.sys_clk, .drive(multi_purpose_pin_drive),
		.ext_en(1'h1), .ext_level(mpp_ext), .level(multi_purpose_pin_in));
	pin_far_side pin_far_side_din_i (.sys_clk, .drive(2'h0),
		.ext_en(1'h1), .ext_level(din_ext), .level(data_in_pin_in));

	// Clock, 50 ns period
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask

	// Read data stands for one cycle only, then drops to zero
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		`CHECK(reg_rdata, exp)
		@(negedge sys_clk);
		`CHECK(reg_rdata, 8'h00)
	endtask

	// Register image for a selector code; reserved bits always written at reset value
	function automatic logic [7:0] wbyte(logic [7:0] a, logic [3:0] c, logic g);
		case (a)
			8'h33: return {2'h0, c, 1'h0, g};
			8'h35: return {4'h1, c[2:0], g};
			default: return {5'h00, c[1:0], 1'h0};
		endcase
	endfunction

	// Main sequence
	initial begin
		row_type    r;
		logic       ph;
		logic [9:0] s;
		// Rows: register, code, {oe, ibuf, route}, source index
		rows = '{'{8'h33, 4'h0, 3'h0, 4'h0}, '{8'h33, 4'h1, 3'h3, 4'h0},
			'{8'h33, 4'h2, 3'h2, 4'h0}, '{8'h33, 4'h3, 3'h6, 4'h0}, '{8'h33, 4'h4, 3'h6, 4'h1},
			'{8'h33, 4'h5, 3'h6, 4'h2}, '{8'h33, 4'h6, 3'h6, 4'h3}, '{8'h33, 4'h7, 3'h6, 4'h4},
			'{8'h33, 4'h8, 3'h6, 4'h5}, '{8'h33, 4'h9, 3'h6, 4'h6}, '{8'h33, 4'hA, 3'h6, 4'h7},
			'{8'h33, 4'hB, 3'h6, 4'h8}, '{8'h33, 4'hC, 3'h0, 4'h0}, '{8'h33, 4'hD, 3'h0, 4'h0},
			'{8'h33, 4'hE, 3'h0, 4'h0}, '{8'h33, 4'hF, 3'h0, 4'h0}, '{8'h35, 4'h0, 3'h0, 4'h0},
			'{8'h35, 4'h1, 3'h4, 4'h9}, '{8'h35, 4'h2, 3'h4, 4'h0}, '{8'h35, 4'h3, 3'h4, 4'h1},
			'{8'h35, 4'h4, 3'h4, 4'h2}, '{8'h35, 4'h5, 3'h4, 4'h3}, '{8'h35, 4'h6, 3'h4, 4'h5},
			'{8'h35, 4'h7, 3'h4, 4'h6}, '{8'h36, 4'h0, 3'h0, 4'h0}, '{8'h36, 4'h1, 3'h3, 4'h0},
			'{8'h36, 4'h2, 3'h2, 4'h0}, '{8'h36, 4'h3, 3'h0, 4'h0}};
		{rst_n, reg_wr, reg_rd, int_flags_read, reg_addr, reg_wdata} = '0;
		{clock_output_signal, adc_word_clock, secondary_bit_clock, secondary_word_clock} = '0;
		{secondary_data_out, mic_modulator_clock, primary_data_out} = '0;
		{int_event, int_repeat, mpp_ext, din_ext} = '0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK(data_out_pin_drive.oe, 1'h1)
		`CHECK(data_out_pin_keeper_en, 1'h0)
		`CHECK(multi_purpose_pin_drive.oe, 1'h0)
		rd_chk(8'h32, 8'h00);
		rd_chk(8'h33, 8'h00);
		rd_chk(8'h34, 8'h00);
		rd_chk(8'h35, 8'h12);
		rd_chk(8'h36, 8'h02);
		// Each row twice: selected source low and all others high, then inverted
		for (int i = 0; i < 28; i++) begin
			for (int p = 0; p < 2; p++) begin
				r = rows[i];
				ph = p[0];
				s = ph ? (10'h001 << r.idx) : ~(10'h001 << r.idx);
				wr(r.addr, wbyte(r.addr, r.code, s[0]));
				@(posedge sys_clk);
				{primary_data_out, secondary_data_out, mic_modulator_clock} <= s[9:7];
				{secondary_word_clock, secondary_bit_clock, adc_word_clock} <= s[6:4];
				int_event <= s[3:2];
				clock_output_signal <= s[1];
				mpp_ext <= ph;
				din_ext <= ph;
				@(posedge sys_clk);
				int_event <= 2'h0;
				repeat (2) @(posedge sys_clk);
				@(negedge sys_clk);
				if (r.addr == 8'h33) begin
					`CHECK(multi_purpose_pin_drive.oe, r.flg[2])
					if (r.flg[2])
						`CHECK(multi_purpose_pin_drive.out, ph)
					`CHECK(multi_purpose_pin_ibuf_en, r.flg[1])
					`CHECK(multi_purpose_pin_route, r.flg[0] & ph)
				end else if (r.addr == 8'h35) begin
					`CHECK(data_out_pin_drive.oe, r.flg[2])
					if (r.flg[2])
						`CHECK(data_out_pin_drive.out, ph)
					`CHECK(data_out_pin_keeper_en, 1'h0)
				end else begin
					`CHECK(data_in_pin_ibuf_en, r.flg[1])
					`CHECK(data_in_pin_route, r.flg[0] & ph)
				end
				// Interrupt pulses end during the read, so their levels are not read back
				if (r.idx < 2 || r.idx > 3)
					rd_chk(r.addr, wbyte(r.addr, r.code, s[0])
						| ({7'h00, r.flg[1] & ph} << (r.addr == 8'h33)));
			end
		end
		// Keeper on with primary data selected
		wr(8'h35, 8'h02);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK(data_out_pin_keeper_en, 1'h1)
		// Unmapped address: write dropped, read gives zero
		wr(8'h40, 8'hFF);
		rd_chk(8'h40, 8'h00);
		// Read-only level bit ignores writes; buffer off reads low
		@(posedge sys_clk);
		mpp_ext <= 1'h1;
		wr(8'h33, 8'h02);
		rd_chk(8'h33, 8'h00);
		// First interrupt repeats, second is a single pulse
		@(posedge sys_clk);
		int_repeat <= 2'h1;
		int_event <= 2'h3;
		@(posedge sys_clk);
		int_event <= 2'h0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK({first_interrupt_output, second_interrupt_output}, 2'h3)
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK({first_interrupt_output, second_interrupt_output}, 2'h0)
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK({first_interrupt_output, second_interrupt_output}, 2'h2)
		@(posedge sys_clk);
		int_flags_read <= 1'h1;
		@(posedge sys_clk);
		int_flags_read <= 1'h0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHECK({first_interrupt_output, second_interrupt_output}, 2'h0)
		// Second reset in mid-run restores the data-output register
		wr(8'h35, 8'h00);
		@(posedge sys_clk);
		rst_n <= 1'h0;
		@(posedge sys_clk);
		rst_n <= 1'h1;
		rd_chk(8'h35, 8'h12);
		complete_run();
	end
endmodule
